// ---- gke_core.sv ----
/*
  gke_core: bus command interpreter: graph, identify, download, keys.
  assumes: verbs and bytes arrive as strobes on this clock; remote
  enable and listen are asynchronous pins.
*/
// How it works
// RULE1: graph verb switches the display to graph mode, no arguments.
// RULE2: identify query answers five comma fields then end of line.
// RULE3: download gives start, stop, then evenly spaced power values.
// RULE4: trace takes 512 values, pathcal and calfactor take 4096.
// RULE5: controller separates values by comma, ends with line feed.
// RULE6: download targets trace 0-9 or sensor A, B, C tables.
// RULE7: frequency has six integer, three decimals; power signed ddd.dd.
// RULE8: bytes right after the download command are the data.
// RULE9: emulation switch on or plus enables, off or minus disables.
// RULE10: emulation on and remote enable false makes bytes keystrokes.
// RULE11: remote enable plus listen address restores parsing, keeps enable.
// RULE12: after device go-to-local, keystrokes until an accepted asterisk.
// RULE13: sixteen-entry in-order key buffer; extra characters dropped.
// RULE14: asterisk lost when buffer full; keystrokes continue.
// RULE15: controller waits 1 s before and 10 ms after go-to-local.
// RULE16: go-to-remote stalls bus commands until keys finish.
// RULE17: controller lets buffered keys drain before sending more.
// RULE18: A-H soft keys, I-U named panel keys.
// RULE19: minus, decimal, digits, lowercase a-i entry and channel keys.
// RULE20: unmapped characters are dropped without using the buffer.
module gke_core
  import gke_pkg::*;
#(
  parameter logic [7:0] ID_MAKER = 8'h4D, // arbitrary value
  parameter logic [7:0] ID_MODEL = 8'h31, // arbitrary value
  parameter logic [7:0] ID_REV = 8'h32,
  parameter logic [7:0] ID_DATE = 8'h33
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire gke_pkg::gke_byte_s rx_byte,
  input wire logic rx_valid,
  input wire logic op_graph,
  input wire logic op_idn,
  input wire logic op_emul_on,
  input wire logic op_emul_off,
  input wire logic op_input,
  input wire gke_pkg::gke_tgt_e input_target,
  input wire logic [3:0] input_index,
  input wire logic go_local_dev,
  input wire logic go_remote,
  input wire logic talk_addr,
  input wire logic tx_ready,
  input wire logic ren_pin,
  input wire logic listen_pin,
  input wire logic key_done,
  output logic graph_mode,
  output logic emul_enable,
  output logic key_mode,
  output logic cmd_stall,
  output logic rx_to_parser,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic [5:0] key_code,
  output logic key_start,
  output gke_pkg::gke_dl_s dl_word,
  output logic dl_valid,
  output logic dl_done,
  output logic dl_error
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once stages two and three agree
  logic [2:0] ren_sync, lsn_sync;
  logic ren, lsn;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {ren_sync, lsn_sync, ren, lsn} <= '0;
    end else begin
      ren_sync <= {ren_sync[1:0], ren_pin};
      lsn_sync <= {lsn_sync[1:0], listen_pin};
      if (ren_sync[1] == ren_sync[2]) begin
        ren <= ren_sync[2];
      end
      if (lsn_sync[1] == lsn_sync[2]) begin
        lsn <= lsn_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // graph display verb: no specifiers, just sets the display mode
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      graph_mode <= 1'b0;
    end else if (op_graph) begin
      graph_mode <= 1'b1; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // emulation switch and the local keystroke state
  logic star_mode, key_full, key_empty, map_valid, is_key_byte;
  logic star_taken, next_key_mode;
  logic [5:0] map_key;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      emul_enable <= 1'b0;
    end else if (op_emul_on && !key_mode) begin
      emul_enable <= 1'b1; // RULE9
    end else if (op_emul_off && !key_mode) begin
      emul_enable <= 1'b0; // RULE9
    end
  end

  // a star only counts if the buffer could have taken it
  assign star_taken = star_mode && rx_valid
                   && rx_byte.data == GKE_CH_STAR && !key_full; // RULE14

  // device-specific local: keys until an accepted star
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      star_mode <= 1'b0;
    end else if (go_remote || star_taken) begin
      star_mode <= 1'b0; // RULE12
    end else if (go_local_dev && emul_enable) begin
      star_mode <= 1'b1; // RULE12
    end
  end

  // remote enable false with emulation on; remote plus listen ends it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_mode <= 1'b0;
    end else begin
      key_mode <= next_key_mode;
    end
  end

  always_comb begin
    next_key_mode = star_mode && !star_taken && !go_remote; // RULE12
    if (emul_enable && !ren) begin
      next_key_mode = 1'b1; // RULE10
    end else if (emul_enable && ren && lsn && !star_mode) begin
      next_key_mode = 1'b0; // RULE11
    end
  end

  assign is_key_byte = key_mode && rx_valid;

  // steer bytes to the parser only outside keystroke mode and stall
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_to_parser <= 1'b1;
    end else begin
      rx_to_parser <= !next_key_mode && !cmd_stall; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key mapping and buffer
  gke_keymap u_map (
    .ch(rx_byte.data),
    .valid(map_valid),
    .key(map_key)
  );

  logic key_busy, key_pop;
  logic [5:0] key_head;

  assign key_pop = !key_busy && !key_empty;

  gke_keyfifo #(.DEPTH(GKE_KEY_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .push(is_key_byte && map_valid), // RULE20
    .din(map_key),
    .pop(key_pop),
    .dout(key_head),
    .empty(key_empty),
    .full(key_full)
  );

  // one key runs at a time; the next starts when the panel says done
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {key_busy, key_start, key_code} <= '0;
    end else begin
      key_start <= key_pop; // RULE13
      if (key_pop) begin
        key_code <= key_head;
        key_busy <= 1'b1;
      end else if (key_done) begin
        key_busy <= 1'b0;
      end
    end
  end

  // go-to-remote holds off commands until every buffered key finished
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_stall <= 1'b0;
    end else if (go_remote && (key_busy || !key_empty)) begin
      cmd_stall <= 1'b1; // RULE16
    end else if (!key_busy && key_empty && !key_pop) begin
      cmd_stall <= 1'b0; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // identify answer: five comma separated fields then line feed
  logic idn_pend, idn_run;
  logic [3:0] idn_pos;

  function automatic logic [7:0] idn_char(input logic [3:0] pos);
    case (pos)
      4'h0: idn_char = ID_MAKER;
      4'h2: idn_char = ID_MODEL;
      4'h4: idn_char = 8'h30; // unused field fixed at zero
      4'h6: idn_char = ID_REV;
      4'h8: idn_char = ID_DATE;
      4'h9: idn_char = GKE_CH_LF;
      default: idn_char = GKE_CH_COMMA;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {idn_pend, idn_run, idn_pos, tx_valid, tx_data} <= '0;
    end else begin
      if (op_idn) begin
        idn_pend <= 1'b1; // RULE2
      end else if (idn_pend && talk_addr) begin
        idn_pend <= 1'b0;
        idn_run <= 1'b1;
        idn_pos <= 4'h0;
      end
      if (idn_run && (!tx_valid || tx_ready)) begin
        tx_valid <= 1'b1;
        tx_data <= idn_char(idn_pos); // RULE2
        idn_pos <= idn_pos + 4'h1;
        if (idn_pos == 4'(2 * GKE_ID_FIELDS - 1)) begin
          idn_run <= 1'b0;
        end
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // download parser: number fields in fixed point, thousandths of unit
  typedef enum logic [1:0] {
    GKE_DL_IDLE = 2'b00,
    GKE_DL_FREQ = 2'b01,
    GKE_DL_PWR = 2'b11
  } gke_dl_e;

  gke_dl_e dl_state;
  gke_tgt_e tgt;
  logic [3:0] tgt_idx;
  logic [12:0] npt;
  logic freq_stop, neg, frac, dl_byte;
  logic [2:0] idig;
  logic [1:0] fdig;
  logic signed [31:0] acc;
  logic [7:0] c;

  assign dl_byte = rx_valid && rx_to_parser && dl_state != GKE_DL_IDLE;
  assign c = rx_byte.data;

  // scale a partial value to thousandths by its missing decimals
  function automatic logic signed [31:0] scale(
    input logic signed [31:0] v, input logic [1:0] f);
    case (f)
      2'h0: scale = v * 32'sd1000;
      2'h1: scale = v * 32'sd100;
      2'h2: scale = v * 32'sd10;
      default: scale = v;
    endcase
  endfunction

  function automatic logic [12:0] expected(input gke_tgt_e t);
    expected = (t == GKE_TGT_TRACE) ? 13'(GKE_TRACE_POINTS)
                                    : 13'(GKE_TABLE_POINTS); // RULE4
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dl_state <= GKE_DL_IDLE;
      tgt <= GKE_TGT_TRACE;
      {tgt_idx, npt, freq_stop, acc, neg, frac, idig, fdig} <= '0;
      {dl_valid, dl_done, dl_error, dl_word} <= '0;
    end else begin
      dl_valid <= 1'b0;
      dl_done <= 1'b0;
      // out-of-range targets are refused at the command
      if (op_input && dl_state == GKE_DL_IDLE) begin
        if ((input_target == GKE_TGT_TRACE
             && input_index < 4'(GKE_NUM_TRACES))
            || (input_target != GKE_TGT_TRACE
             && input_index < 4'h3)) begin
          dl_state <= GKE_DL_FREQ; // RULE6 RULE8
          tgt <= input_target;
          tgt_idx <= input_index;
          npt <= 13'h0000;
          freq_stop <= 1'b0;
          dl_error <= 1'b0;
        end else begin
          dl_error <= 1'b1; // RULE6
        end
        {acc, neg, frac, idig, fdig} <= '0;
      end else if (dl_byte) begin
        if (c >= 8'h30 && c <= 8'h39) begin
          // extra digits beyond the field width flag a format fault
          if (frac) begin
            if (fdig < 2'((dl_state == GKE_DL_FREQ)
                          ? GKE_FRAC_DIGITS_FREQ : GKE_FRAC_DIGITS_PWR))
            begin
              acc <= 32'(acc * 10 + 32'(c - 8'h30)); // RULE7
              fdig <= fdig + 2'h1;
            end else begin
              dl_error <= 1'b1;
            end
          end else if (idig < 3'((dl_state == GKE_DL_FREQ)
                           ? GKE_FREQ_INT_DIGITS : GKE_PWR_INT_DIGITS))
          begin
            acc <= 32'(acc * 10 + 32'(c - 8'h30)); // RULE7
            idig <= idig + 3'h1;
          end else begin
            dl_error <= 1'b1;
          end
        end else if (c == GKE_CH_DOT) begin
          frac <= 1'b1;
        end else if (c == GKE_CH_MINUS && dl_state == GKE_DL_PWR) begin
          neg <= 1'b1; // RULE7
        end else if (c == GKE_CH_PLUS || c == GKE_CH_SPACE) begin
          neg <= neg;
        end else if (c == GKE_CH_COMMA || c == GKE_CH_LF) begin
          // a value closes on a comma or the final line feed
          dl_valid <= 1'b1; // RULE5
          dl_word.target <= tgt;
          dl_word.index <= tgt_idx;
          dl_word.point <= npt;
          dl_word.is_freq <= (dl_state == GKE_DL_FREQ);
          dl_word.is_stop <= freq_stop;
          dl_word.value <= neg ? -scale(acc, fdig) : scale(acc, fdig);
          {acc, neg, frac, idig, fdig} <= '0;
          if (dl_state == GKE_DL_FREQ) begin
            freq_stop <= 1'b1; // RULE3
            if (freq_stop) begin
              dl_state <= GKE_DL_PWR;
            end
            if (c == GKE_CH_LF) begin
              dl_state <= GKE_DL_IDLE;
              dl_error <= 1'b1;
            end
          end else begin
            npt <= npt + 13'h0001; // RULE3
            if (c == GKE_CH_LF) begin
              dl_state <= GKE_DL_IDLE;
              dl_done <= 1'b1;
              dl_error <= (npt + 13'h0001 != expected(tgt)); // RULE4
            end else if (npt + 13'h0001 == expected(tgt)) begin
              dl_error <= 1'b1; // RULE4
            end
          end
        end else begin
          dl_error <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- gke_pkg.sv ----
/*
  gke_pkg: constants and types of the keystroke emulator.
  assumes: one 125 MHz clock, asynchronous active-low reset everywhere but the key buffer storage.
*/
package gke_pkg;

  // character codes the parser and emulator look at
  localparam logic [7:0] GKE_CH_STAR = 8'h2A;
  localparam logic [7:0] GKE_CH_COMMA = 8'h2C;
  localparam logic [7:0] GKE_CH_MINUS = 8'h2D;
  localparam logic [7:0] GKE_CH_PLUS = 8'h2B;
  localparam logic [7:0] GKE_CH_DOT = 8'h2E;
  localparam logic [7:0] GKE_CH_LF = 8'h0A;
  localparam logic [7:0] GKE_CH_SPACE = 8'h20;

  // panel key codes: 0..7 soft keys, 8..20 named keys, 21 minus,
  // 22 decimal point, 23..32 digits, 33..36 entry keys, 37..41 channel
  localparam logic [5:0] GKE_KEY_SOFT1 = 6'h00;
  localparam logic [5:0] GKE_KEY_DEFINE = 6'h08;
  localparam logic [5:0] GKE_KEY_MINUS = 6'h15;
  localparam logic [5:0] GKE_KEY_DECPT = 6'h16;
  localparam logic [5:0] GKE_KEY_DIGIT0 = 6'h17;
  localparam logic [5:0] GKE_KEY_ENTOFF = 6'h21;

  // download lengths and targets, key buffer depth, identify field count
  localparam int GKE_TRACE_POINTS = 512;
  localparam int GKE_TABLE_POINTS = 4096;
  localparam int GKE_NUM_TRACES = 10;
  localparam int GKE_KEY_DEPTH = 16;
  localparam int GKE_ID_FIELDS = 5;

  // field widths of the fixed point values
  localparam int GKE_FREQ_INT_DIGITS = 6;
  localparam int GKE_FRAC_DIGITS_FREQ = 3;
  localparam int GKE_PWR_INT_DIGITS = 3;
  localparam int GKE_FRAC_DIGITS_PWR = 2;

  typedef enum logic [1:0] {
    GKE_TGT_TRACE = 2'h0,
    GKE_TGT_PATHCAL = 2'h1,
    GKE_TGT_CALFACT = 2'h2
  } gke_tgt_e;

  // one parsed download value, handed to the table store
  typedef struct packed {
    gke_tgt_e target;
    logic [3:0] index;
    logic [12:0] point;
    logic is_freq;
    logic is_stop;
    logic signed [31:0] value;
  } gke_dl_s;

  // one received bus byte with its end marker
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gke_byte_s;

endpackage

// ---- gke_keymap.sv ----
/*
  gke_keymap: turns one ASCII character into a panel key code.
  assumes: combinational.
*/
module gke_keymap
  import gke_pkg::*;
(
  input wire logic [7:0] ch,
  output logic valid,
  output logic [5:0] key
);

  // letters and digits are contiguous ranges, so offsets suffice
  always_comb begin
    valid = 1'b1;
    key = GKE_KEY_SOFT1;
    if (ch >= 8'h41 && ch <= 8'h48) begin
      key = GKE_KEY_SOFT1 + 6'(ch - 8'h41); // RULE18
    end else if (ch >= 8'h49 && ch <= 8'h55) begin
      key = GKE_KEY_DEFINE + 6'(ch - 8'h49); // RULE18
    end else if (ch == GKE_CH_MINUS) begin
      key = GKE_KEY_MINUS; // RULE19
    end else if (ch == GKE_CH_DOT) begin
      key = GKE_KEY_DECPT; // RULE19
    end else if (ch >= 8'h30 && ch <= 8'h39) begin
      key = GKE_KEY_DIGIT0 + 6'(ch - 8'h30); // RULE19
    end else if (ch >= 8'h61 && ch <= 8'h69) begin
      key = GKE_KEY_ENTOFF + 6'(ch - 8'h61); // RULE19
    end else begin
      valid = 1'b0; // RULE20
    end
  end

endmodule

// ---- gke_keyfifo.sv ----
/*
  gke_keyfifo: in-order keystroke buffer of fixed depth.
  assumes: push is dropped when full; pop only when not empty.
*/
module gke_keyfifo
  import gke_pkg::*;
#(
  parameter int DEPTH = GKE_KEY_DEPTH
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic push,
  input wire logic [5:0] din,
  input wire logic pop,
  output logic [5:0] dout,
  output logic empty,
  output logic full
);

  localparam int AW = $clog2(DEPTH);
  logic [5:0] mem [DEPTH];
  logic [AW:0] count;
  logic [AW-1:0] rd;
  logic [AW-1:0] wr;
  logic do_push;
  logic do_pop;

  // a full buffer silently loses the character
  assign do_push = push && !full; // RULE13
  assign do_pop = pop && !empty;
  assign empty = (count == '0);
  assign full = (count == (AW+1)'(DEPTH));
  assign dout = mem[rd];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr] <= din;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr <= '0;
      rd <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr <= wr + 1'b1;
      end
      if (do_pop) begin
        rd <= rd + 1'b1; // RULE13
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule

// ---- gke_core_sva.sv ----
/*
  gke_core_sva: port checks of the core.
  assumes: bound to gke_core; one clock, rstn asynchronous active low.
*/
module gke_core_sva
  import gke_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic op_graph,
  input wire logic op_emul_on,
  input wire logic op_emul_off,
  input wire logic tx_ready,
  input wire logic graph_mode,
  input wire logic emul_enable,
  input wire logic key_mode,
  input wire logic cmd_stall,
  input wire logic rx_to_parser,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic [5:0] key_code,
  input wire logic key_start,
  input wire logic dl_valid,
  input wire logic dl_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // a reply byte held back, and modes that last two cycles
  sequence s_tx_wait; tx_valid && !tx_ready; endsequence
  sequence s_keys2; key_mode ##1 key_mode; endsequence
  sequence s_stall2; cmd_stall ##1 cmd_stall; endsequence
  // verb effects land on the next edge
  property p_graph_set; op_graph |=> graph_mode; endproperty
  a_graph_set: assert property (p_graph_set)
    else $error("graph verb did not set graph mode");
  property p_graph_keep; graph_mode |=> graph_mode; endproperty
  a_graph_keep: assert property (p_graph_keep)
    else $error("graph mode dropped");
  property p_emul_on; op_emul_on && !key_mode |=> emul_enable; endproperty
  a_emul_on: assert property (p_emul_on)
    else $error("emulation switch on ignored");
  property p_emul_off;
    op_emul_off && !op_emul_on && !key_mode |=> !emul_enable;
  endproperty
  a_emul_off: assert property (p_emul_off)
    else $error("emulation switch off ignored");
  property p_emul_keep; emul_enable && !op_emul_off |=> emul_enable; endproperty
  a_emul_keep: assert property (p_emul_keep)
    else $error("emulation enable lost");
  // bytes stay away from the parser in key mode and while stalled
  property p_key_parse; s_keys2 |-> !rx_to_parser; endproperty
  a_key_parse: assert property (p_key_parse)
    else $error("parser fed while in key mode");
  property p_stall_parse; s_stall2 |-> !rx_to_parser; endproperty
  a_stall_parse: assert property (p_stall_parse)
    else $error("parser fed while stalled");
  property p_key_pulse; key_start |=> !key_start; endproperty
  a_key_pulse: assert property (p_key_pulse)
    else $error("key start longer than one cycle");
  property p_key_range; key_start |-> key_code <= 6'h29; endproperty
  a_key_range: assert property (p_key_range)
    else $error("key code out of range");
  property p_tx_hold; s_tx_wait |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("reply byte changed before taken");
  property p_dl_gap; dl_valid |=> !dl_valid; endproperty
  a_dl_gap: assert property (p_dl_gap)
    else $error("two values without a separator");
  property p_dl_done; dl_done |=> !dl_done; endproperty
  a_dl_done: assert property (p_dl_done)
    else $error("download end pulse too long");
endmodule
bind gke_core gke_core_sva u_sva (.clock(clock), .rstn(rstn),
  .op_graph(op_graph), .op_emul_on(op_emul_on), .tx_ready(tx_ready),
  .op_emul_off(op_emul_off), .graph_mode(graph_mode), .key_mode(key_mode),
  .emul_enable(emul_enable), .cmd_stall(cmd_stall), .tx_data(tx_data),
  .rx_to_parser(rx_to_parser), .tx_valid(tx_valid), .key_code(key_code),
  .key_start(key_start), .dl_valid(dl_valid), .dl_done(dl_done));

// ---- gke_ctrl_model.sv ----
/*
  gke_ctrl_model: far side: identify reader and key-finishing panel.
  assumes: instanced in tb_top; hold freezes key completion.
*/
module gke_ctrl_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold,
  input wire logic key_start,
  output logic tx_ready,
  output logic key_done
);
  logic [2:0] pace;
  logic [3:0] busy;
  // reader takes two cycles then stalls two, so both speeds are seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pace <= 3'h0;
      tx_ready <= 1'b0;
    end else begin
      pace <= pace + 3'h1;
      tx_ready <= pace[1];
    end
  end
  // key time varies with pace; a slow function is modelled by hold
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 4'h0;
      key_done <= 1'b0;
    end else begin
      key_done <= 1'b0;
      if (key_start) begin
        busy <= {1'b0, pace} + 4'h3;
      end else if (busy == 4'h1 && !hold) begin
        busy <= 4'h0;
        key_done <= 1'b1;
      end else if (busy > 4'h1) begin
        busy <= busy - 4'h1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
/*
  tb_top: self-checking bench for gke_core.
  assumes: one 8 ns clock; expected results queued by the driver.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gke_pkg::*;
  localparam logic [7:0] MK = 8'h56; // arbitrary value
  localparam logic [7:0] MD = 8'h57; // arbitrary value
  localparam logic [7:0] RV = 8'h52;
  localparam logic [7:0] DT = 8'h44;
  logic clock, rstn, rx_valid, hold, go_local_dev, go_remote, talk_addr;
  logic ren_pin, listen_pin, tx_ready, key_done, graph_mode, emul_enable;
  logic key_mode, cmd_stall, rx_to_parser, tx_valid, key_start;
  logic dl_valid, dl_done, dl_error;
  logic [4:0] ops;
  logic [3:0] idx;
  logic [7:0] tx_data;
  logic [5:0] key_code;
  logic [31:0] lfsr;
  gke_byte_s rx_byte;
  gke_tgt_e tgt;
  gke_dl_s dl_word;
  int fail_count, compares, key_q[$];
  logic [7:0] tx_q[$];
  gke_dl_s dl_q[$];
  gke_core #(.ID_MAKER(MK), .ID_MODEL(MD), .ID_REV(RV), .ID_DATE(DT)) dut (
    .clock(clock), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .op_graph(ops[0]), .op_idn(ops[1]), .op_emul_on(ops[2]),
    .op_emul_off(ops[3]), .op_input(ops[4]), .input_target(tgt),
    .input_index(idx), .go_local_dev(go_local_dev), .go_remote(go_remote),
    .talk_addr(talk_addr), .tx_ready(tx_ready), .ren_pin(ren_pin),
    .listen_pin(listen_pin), .key_done(key_done), .graph_mode(graph_mode),
    .emul_enable(emul_enable), .key_mode(key_mode), .cmd_stall(cmd_stall),
    .rx_to_parser(rx_to_parser), .tx_data(tx_data), .tx_valid(tx_valid),
    .key_code(key_code), .key_start(key_start), .dl_word(dl_word),
    .dl_valid(dl_valid), .dl_done(dl_done), .dl_error(dl_error));
  gke_ctrl_model far (.clock(clock), .rstn(rstn), .hold(hold),
    .key_start(key_start), .tx_ready(tx_ready), .key_done(key_done));
  ////////////////////////////////////////////////////////////////////////
  // free-running clock and time-zero input values
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {rstn, rx_valid, hold, go_local_dev, go_remote, talk_addr} = '0;
    {ren_pin, listen_pin, ops, idx, rx_byte} = '0;
    {fail_count, compares} = '0;
    tgt = GKE_TGT_TRACE;
    lfsr = 32'hD2F8393F;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected panel key of a character, -1 where none
  function automatic int kc(byte c);
    if (c >= "A" && c <= "U") return c - "A";
    if (c == "-") return GKE_KEY_MINUS;
    if (c == ".") return GKE_KEY_DECPT;
    if (c >= "0" && c <= "9") return GKE_KEY_DIGIT0 + c - "0";
    if (c >= "a" && c <= "i") return GKE_KEY_ENTOFF + c - "a";
    return -1;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic op(int b);
    @(posedge clock) ops <= 5'h01 << b;
    @(posedge clock) ops <= 5'h00;
  endtask
  // bytes go back to back, the strobe held up across them
  task automatic put(string s);
    foreach (s[i]) begin
      @(posedge clock);
      rx_byte <= '{data: s[i], eoi: 1'b0};
      rx_valid <= 1'b1;
    end
    @(posedge clock) rx_valid <= 1'b0;
  endtask
  task automatic keys(string s);
    foreach (s[i]) if (kc(s[i]) >= 0) key_q.push_back(kc(s[i]));
    put(s);
  endtask
  task automatic drain;
    for (int i = 0; i < 3000 && key_q.size() > 0; i++) tick(1);
    tick(20);
  endtask
  task automatic pins(logic r, logic l);
    @(posedge clock);
    ren_pin <= r;
    listen_pin <= l;
    tick(8);
  endtask
  // download: two freqs, n random powers
  task automatic load(gke_tgt_e t, logic [3:0] x, int n, logic err);
    gke_dl_s w;
    int v;
    @(posedge clock);
    tgt <= t;
    idx <= x;
    op(4);
    w = '0;
    w.target = t;
    w.index = x;
    w.is_freq = 1'b1;
    w.value = 2000000;
    dl_q.push_back(w);
    w.is_stop = 1'b1;
    w.value = 4000500;
    dl_q.push_back(w);
    put("2000.000,4000.500,");
    w.is_freq = 1'b0;
    for (int p = 0; p < n; p++) begin
      lfsr = nx(lfsr);
      v = lfsr[9:0] % 1000;
      w.point = 13'(p);
      w.value = v * 1000 + (lfsr[11] ? 250 : 500);
      if (lfsr[10]) w.value = -w.value;
      dl_q.push_back(w);
      put($sformatf("%s%0d.%0d%s", lfsr[10] ? "-" : "+", v,
        lfsr[11] ? 25 : 50, p == n - 1 ? "\n" : ","));
    end
    for (int i = 0; i < 60 && dl_done !== 1'b1; i++) tick(1);
    tick(2);
    chk("dl_error", err, dl_error);
  endtask
  // watcher: oldest note per result
  always @(posedge clock) begin
    if (rstn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1)
      chk("tx_data", tx_q.size() ? tx_q.pop_front() : 9'h100, tx_data);
    if (rstn === 1'b1 && key_start === 1'b1)
      chk("key_code", key_q.size() ? key_q.pop_front() : 99, key_code);
    if (rstn === 1'b1 && dl_valid === 1'b1) begin
      if (dl_q.size() == 0) chk("dl_extra", 0, 1);
      else chk("dl_word", dl_q.pop_front(), dl_word);
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(8 * 90000);
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(12);
    chk("rx_to_parser", 1, rx_to_parser);
    @(posedge clock) rstn <= 1'b1;
    tick(6);
    chk("graph_mode", 0, graph_mode);
    op(0);
    tick(1);
    chk("graph_mode", 1, graph_mode);
    tx_q = '{MK, ",", MD, ",", "0", ",", RV, ",", DT, "\n"};
    op(1);
    @(posedge clock) talk_addr <= 1'b1;
    for (int i = 0; i < 200 && tx_q.size() > 0; i++) tick(1);
    @(posedge clock) talk_addr <= 1'b0;
    load(GKE_TGT_TRACE, 4'(nx(lfsr) % 10), GKE_TRACE_POINTS, 0);
    load(GKE_TGT_PATHCAL, 4'h1, GKE_TABLE_POINTS, 0);
    load(GKE_TGT_CALFACT, 4'h2, 3, 1);
    @(posedge clock) idx <= 4'hA;
    op(4);
    tick(3);
    chk("dl_error", 1, dl_error);
    op(2);
    tick(2);
    chk("emul_enable", 1, emul_enable);
    pins(1'b0, 1'b0);
    chk("key_mode", 1, key_mode);
    keys("ABCDEFGH");
    drain();
    keys("IJKLMNOP");
    drain();
    keys("QRSTU-.z");
    drain();
    keys("01234567");
    drain();
    keys("89abcdefghi~");
    drain();
    chk("rx_to_parser", 0, rx_to_parser);
    pins(1'b1, 1'b1);
    chk("key_mode", 0, key_mode);
    chk("emul_enable", 1, emul_enable);
    pins(1'b0, 1'b0);
    hold <= 1'b1;
    keys("ABC");
    @(posedge clock) go_remote <= 1'b1;
    ren_pin <= 1'b1;
    listen_pin <= 1'b1;
    @(posedge clock) go_remote <= 1'b0;
    tick(8);
    chk("cmd_stall", 1, cmd_stall);
    hold <= 1'b0;
    drain();
    chk("cmd_stall", 0, cmd_stall);
    @(posedge clock) go_local_dev <= 1'b1;
    @(posedge clock) go_local_dev <= 1'b0;
    tick(2);
    chk("key_mode", 1, key_mode);
    hold <= 1'b1;
    keys("A");
    tick(6);
    keys("BCDEFGHIJKLMNOPQ");
    put("RST*");
    tick(4);
    chk("key_mode", 1, key_mode);
    hold <= 1'b0;
    drain();
    put("*");
    tick(4);
    chk("key_mode", 0, key_mode);
    op(3);
    tick(2);
    chk("emul_enable", 0, emul_enable);
    pins(1'b0, 1'b0);
    chk("key_mode", 0, key_mode);
    chk("queues", 0, tx_q.size() + key_q.size() + dl_q.size());
    final_report();
  end
endmodule
